//--- core/mecr_pkg.sv
// Package: constants and types shared by the memory error correct/report block
`default_nettype none
package mecr_pkg;
  // ---------------------------------------------------------------------
  // Word and code widths
  // ---------------------------------------------------------------------
  localparam int DATA_W   = 24;             // Data bits per word
  localparam int CHK_W    = 5;              // Hamming check bits per word
  localparam int ADDR_W   = 20;             // Physical word address width
  localparam int CODE_W   = DATA_W + CHK_W; // Stored code word width
  localparam int DEPTH    = 64;             // Modelled storage words

  // ---------------------------------------------------------------------
  // Capture register layout
  // ---------------------------------------------------------------------
  localparam int CAP_W        = 24;         // Capture register width
  localparam int CAP_ADDR_LSB = 0;          // Address field low bit
  localparam int CAP_ADDR_MSB = 19;         // Address field high bit
  localparam int CAP_ZERO_LSB = 20;         // Always-zero field low bit
  localparam int CAP_ZERO_MSB = 21;         // Always-zero field high bit
  localparam int CAP_CAUSE_LSB = 22;        // Cause field low bit
  localparam int CAP_CAUSE_MSB = 23;        // Cause field high bit
  localparam logic [23:0] CAP_RESET = 24'h000000; // Capture reset value

  // Error cause encodings
  localparam logic [1:0] CAUSE_IFETCH  = 2'h0; // Instruction fetch
  localparam logic [1:0] CAUSE_OPERAND = 2'h1; // Operand access
  localparam logic [1:0] CAUSE_IO      = 2'h2; // I/O access
  localparam logic [1:0] CAUSE_TIMEOUT = 2'h3; // No memory response

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ       = 50;        // System clock rate
  localparam int TIMEOUT_US    = 10;        // No-response limit
  localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ; // Cycles to limit

  // Sequencer states, Gray along the read/retry path
  typedef enum logic [2:0] {
    MECR_IDLE   = 3'h0,
    MECR_READ   = 3'h1,
    MECR_RETRY  = 3'h3,
    MECR_WBACK  = 3'h2,
    MECR_WRITE  = 3'h6
  } mecr_state_t;
endpackage : mecr_pkg
`default_nettype wire

//--- core/mecr_ham_enc.sv
// Hamming check-bit generator for one 24-bit data word
`default_nettype none
module mecr_ham_enc (
  // Data in
  input  wire logic [23:0] data,
  // Check bits out
  output logic      [4:0]  chk
);
  // ---------------------------------------------------------------------
  // Check bit k covers every data bit whose code position has bit k set
  // ---------------------------------------------------------------------
  // Position of data bit i in the 29-bit code, skipping powers of two
  function automatic logic [4:0] mecr_pos(input int i);
    int p;
    int n;
    p = 0;
    n = -1;
    for (int q = 1; q < 32; q++) begin
      if ((q & (q - 1)) != 0 && n < i) begin
        n = n + 1;
        p = q;
      end
    end
    return p[4:0];
  endfunction : mecr_pos

  // Parity trees, one per check bit
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_chk
      always_comb begin
        logic [4:0] pos;                  // Code position of data bit i
        pos    = 5'h00;
        chk[k] = 1'b0;
        for (int i = 0; i < 24; i++) begin
          pos = mecr_pos(i);
          if (pos[k]) begin
            chk[k] = chk[k] ^ data[i];
          end
        end
      end
    end
  endgenerate
endmodule : mecr_ham_enc
`default_nettype wire

//--- core/mecr_ham_dec.sv
// Hamming syndrome check and single-bit correction for one word
`default_nettype none
module mecr_ham_dec (
  // Stored code word
  input  wire logic [23:0] data,
  input  wire logic [4:0]  chk,
  // Corrected result
  output logic      [23:0] fixed,
  output logic             err
);
  logic [4:0] regen;                 // Check bits regenerated from data
  logic [4:0] syn;                   // Syndrome: code position in error

  // ---------------------------------------------------------------------
  // Regenerate and compare
  // ---------------------------------------------------------------------
  mecr_ham_enc u_enc (
    .data (data),
    .chk  (regen)
  );

  assign syn = regen ^ chk;
  assign err = (syn != 5'h00);

  // Invert the data bit whose code position the syndrome names; a
  // syndrome pointing at a check bit leaves data untouched
  always_comb begin
    int p;
    p = 0;
    fixed = data;
    for (int q = 1; q < 32; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (p < 24 && syn == q[4:0]) begin
          fixed[p] = ~data[p];
        end
        p = p + 1;
      end
    end
  end
endmodule : mecr_ham_dec
`default_nettype wire

//--- core/mecr_top.sv
// Memory error correct/report: ECC storage, retry, capture, interrupts
`default_nettype none
module mecr_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Memory request from CPU or I/O channel
  input  wire logic        req,
  input  wire logic        req_we,
  input  wire logic [19:0] req_addr,
  input  wire logic [23:0] req_wdata,
  input  wire logic [1:0]  req_cause,
  // Parity-only (no correction) module select
  input  wire logic        parity_only,
  // Storage response present; absence for 10 us is a time-out
  input  wire logic        mem_respond,
  // Fault injection for test: flips stored bits on write
  input  wire logic [28:0] inject_flip,
  // Answer to requester
  output logic             ack,
  output logic [23:0]      rdata,
  // Error reporting
  output logic             error_indicator_lamp,
  output logic             exec_trap_irq,
  output logic             ext_prio_irq,
  // Capture register access instructions
  input  wire logic        read_error_address_instr,
  input  wire logic        load_error_address_instr,
  input  wire logic [23:0] accum_in,
  output logic [23:0]      error_address_capture
);
  // ---------------------------------------------------------------------
  // Storage and data register
  // ---------------------------------------------------------------------
  logic [28:0] mem_ff [mecr_pkg::DEPTH];  // Data with check bits
  logic [23:0] mdr_ff;                    // Memory data register
  logic [19:0] mdr_addr_ff;               // Address held by data register
  logic        mdr_valid_ff;              // Data register holds a word
  logic [19:0] addr_ff;                   // Address in service
  logic [23:0] wdata_ff;                  // Write data in service
  logic [1:0]  cause_ff;                  // Access kind in service
  logic        first_err_ff;              // First read saw an error
  mecr_pkg::mecr_state_t state_ff;        // Sequencer state
  logic [8:0]  tmo_cnt_ff;                // No-response counter

  logic [4:0]  wr_chk;                    // Check bits for write data
  logic [23:0] wb_chk_src;                // Word whose check bits we store
  logic [28:0] rd_word;                   // Stored word at addr_ff
  logic [23:0] rd_fixed;                  // Corrected data
  logic        rd_err;                    // Syndrome non-zero
  logic        ecc_err;                   // Error as seen by this module
  logic        ecc_fixable;               // Repair leaves a clean code word
  logic [5:0]  idx;                       // Storage index
  logic        hit;                       // Data register bypass
  logic        tmo_hit;                   // Time-out reached
  logic        hard_ev;                   // Hard error this cycle
  logic        soft_ev;                   // Soft error this cycle
  logic [1:0]  ev_cause;                  // Cause of this event

  assign idx     = addr_ff[5:0];
  assign rd_word = mem_ff[idx];
  // Fast path: same address as the last access, no cycle between
  assign hit = mdr_valid_ff && (req_addr == mdr_addr_ff) && !req_we;
  assign tmo_hit = (tmo_cnt_ff == 9'(mecr_pkg::TIMEOUT_CYC - 1));

  // Write path encodes write data, write-back encodes corrected data
  assign wb_chk_src = (state_ff == mecr_pkg::MECR_WRITE) ? wdata_ff : rd_fixed;

  // ---------------------------------------------------------------------
  // Encoder and decoder
  // ---------------------------------------------------------------------
  mecr_ham_enc u_enc (
    .data (wb_chk_src),
    .chk  (wr_chk)
  );

  mecr_ham_dec u_dec (
    .data  (rd_word[23:0]),
    .chk   (rd_word[28:24]),
    .fixed (rd_fixed),
    .err   (rd_err)
  );

  // A parity-only module has no correction, so every error is retried
  // and seen again: it can only ever be classed as hard
  assign ecc_err = rd_err;
  // A syndrome naming no code bit is beyond repair and is not written
  // back; a double error that aliases one bit is still miscorrected
  assign ecc_fixable = ($countones(wr_chk ^ rd_word[28:24]) < 2);

  // ---------------------------------------------------------------------
  // Sequencer: read, retry, write back, write
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff     <= mecr_pkg::MECR_IDLE;
      addr_ff      <= 20'h00000;
      wdata_ff     <= 24'h000000;
      cause_ff     <= 2'h0;
      first_err_ff <= 1'b0;
    end else begin
      case (state_ff)
        // Take a new request unless the data register answers it
        mecr_pkg::MECR_IDLE: begin
          if (req && !hit) begin
            addr_ff  <= req_addr;
            wdata_ff <= req_wdata;
            cause_ff <= req_cause;
            state_ff <= req_we ? mecr_pkg::MECR_WRITE
                               : mecr_pkg::MECR_READ;
          end
        end
        // First read; wait here for storage to respond
        mecr_pkg::MECR_READ: begin
          if (tmo_hit) begin
            state_ff <= mecr_pkg::MECR_IDLE;
          end else if (mem_respond) begin
            first_err_ff <= ecc_err;
            state_ff <= ecc_err ? mecr_pkg::MECR_RETRY
                                : mecr_pkg::MECR_IDLE;
          end
        end
        // Re-read of the repaired word; classify, then answer
        mecr_pkg::MECR_RETRY: begin
          if (tmo_hit) begin
            state_ff <= mecr_pkg::MECR_IDLE;
          end else if (mem_respond) begin
            state_ff <= mecr_pkg::MECR_WBACK;
          end
        end
        // Answer with the word as the retry read it
        mecr_pkg::MECR_WBACK: begin
          state_ff <= mecr_pkg::MECR_IDLE;
        end
        // Write cycle waits for storage too
        mecr_pkg::MECR_WRITE: begin
          if (tmo_hit || mem_respond) begin
            state_ff <= mecr_pkg::MECR_IDLE;
          end
        end
        default: begin
          state_ff <= mecr_pkg::MECR_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Time-out counter: runs while a storage cycle awaits response
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tmo_cnt_ff <= 9'h000;
    end else if ((state_ff == mecr_pkg::MECR_READ
                  || state_ff == mecr_pkg::MECR_RETRY
                  || state_ff == mecr_pkg::MECR_WRITE)
                 && !mem_respond && !tmo_hit) begin
      tmo_cnt_ff <= tmo_cnt_ff + 9'h001;
    end else begin
      tmo_cnt_ff <= 9'h000;
    end
  end

  // ---------------------------------------------------------------------
  // Storage writes: new data or corrected write-back, 5 check bits each
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state_ff == mecr_pkg::MECR_WRITE && mem_respond && !tmo_hit) begin
      mem_ff[idx] <= {wr_chk, wdata_ff} ^ inject_flip;
    end else if (state_ff == mecr_pkg::MECR_READ && mem_respond
                 && !tmo_hit && ecc_err && ecc_fixable
                 && !parity_only) begin
      // Repaired before the retry, so a corrected error retries clean
      mem_ff[idx] <= {wr_chk, rd_fixed};
    end
  end

  // ---------------------------------------------------------------------
  // Data register and answer to the requester
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mdr_ff       <= 24'h000000;
      mdr_addr_ff  <= 20'h00000;
      mdr_valid_ff <= 1'b0;
      ack          <= 1'b0;
      rdata        <= 24'h000000;
    end else begin
      ack <= 1'b0;
      if (state_ff == mecr_pkg::MECR_IDLE && req && hit) begin
        ack   <= 1'b1;
        rdata <= mdr_ff;
      end else if (state_ff == mecr_pkg::MECR_READ && mem_respond
                   && !tmo_hit && !ecc_err) begin
        ack          <= 1'b1;
        rdata        <= rd_fixed;
        mdr_ff       <= rd_fixed;
        mdr_addr_ff  <= addr_ff;
        mdr_valid_ff <= 1'b1;
      end else if (state_ff == mecr_pkg::MECR_WBACK) begin
        // Requester only ever sees the corrected word
        ack          <= 1'b1;
        rdata        <= rd_fixed;
        mdr_ff       <= rd_fixed;
        mdr_addr_ff  <= addr_ff;
        mdr_valid_ff <= 1'b1;
      end else if (state_ff == mecr_pkg::MECR_WRITE
                   && (mem_respond || tmo_hit)) begin
        ack          <= 1'b1;
        mdr_valid_ff <= 1'b0;               // A write cycle ends bypass
      end else if (state_ff != mecr_pkg::MECR_IDLE && tmo_hit) begin
        ack          <= 1'b1;
        mdr_valid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Error classification
  // ---------------------------------------------------------------------
  always_comb begin
    hard_ev  = 1'b0;
    soft_ev  = 1'b0;
    ev_cause = cause_ff;
    if (state_ff != mecr_pkg::MECR_IDLE
        && state_ff != mecr_pkg::MECR_WBACK && tmo_hit) begin
      hard_ev  = 1'b1;
      ev_cause = mecr_pkg::CAUSE_TIMEOUT;
    end else if (state_ff == mecr_pkg::MECR_RETRY && mem_respond) begin
      if (ecc_err || parity_only) begin
        hard_ev = 1'b1;
      end else begin
        soft_ev = first_err_ff;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Lamp and interrupt pulses; detection never stops service
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_indicator_lamp <= 1'b0;
      exec_trap_irq        <= 1'b0;
      ext_prio_irq         <= 1'b0;
    end else begin
      // Lamp stays lit once a first read sees an ECC error, corrected or not; a time-out does not light it
      if (state_ff == mecr_pkg::MECR_READ && mem_respond && ecc_err) begin
        error_indicator_lamp <= 1'b1;
      end
      exec_trap_irq <= hard_ev;
      ext_prio_irq  <= soft_ev;
    end
  end

  // ---------------------------------------------------------------------
  // Capture register: priority hard over soft, re-armed by a read
  // ---------------------------------------------------------------------
  logic held_soft_ff;                       // Holds a soft error
  logic held_hard_ff;                       // Holds a hard error

  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_address_capture <= mecr_pkg::CAP_RESET;
      held_soft_ff          <= 1'b0;
      held_hard_ff          <= 1'b0;
    end else if (load_error_address_instr) begin
      // Diagnostic load; bits 21:20 forced to zero
      error_address_capture <= {accum_in[23:22], 2'h0,
                                accum_in[19:0]};
    end else if (hard_ev && !held_hard_ff) begin
      // A hard error replaces any held soft error
      error_address_capture <= {ev_cause, 2'h0, addr_ff};
      held_hard_ff          <= 1'b1;
      held_soft_ff          <= 1'b0;
    end else if (soft_ev && !held_soft_ff && !held_hard_ff) begin
      error_address_capture <= {ev_cause, 2'h0, addr_ff};
      held_soft_ff          <= 1'b1;
    end else if (read_error_address_instr) begin
      // An event captured in the same cycle wins; otherwise re-arm
      held_soft_ff <= 1'b0;
      held_hard_ff <= 1'b0;
    end
  end
endmodule : mecr_top
`default_nettype wire

//--- testbench/mecr_assertions.sv
// Checker: concurrent assertions on the memory error block's ports
`default_nettype none
module mecr_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Requests and answers
  input wire logic        req,
  input wire logic        req_we,
  input wire logic [19:0] req_addr,
  input wire logic [23:0] req_wdata,
  input wire logic [1:0]  req_cause,
  input wire logic        parity_only,
  input wire logic        mem_respond,
  input wire logic [28:0] inject_flip,
  input wire logic        ack,
  input wire logic [23:0] rdata,
  // Reporting and capture
  input wire logic        error_indicator_lamp,
  input wire logic        exec_trap_irq,
  input wire logic        ext_prio_irq,
  input wire logic        read_error_address_instr,
  input wire logic        load_error_address_instr,
  input wire logic [23:0] accum_in,
  input wire logic [23:0] error_address_capture
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  logic [15:0] wait_cnt_ff;  // Cycles the open request has waited
  logic [23:0] load_val_ff;  // Value a load would leave in capture
  // Count only while a request is open and unanswered
  always_ff @(posedge clk) begin
    if (!resetn || !req || ack) wait_cnt_ff <= 16'h0000;
    else wait_cnt_ff <= wait_cnt_ff + 16'h0001;
  end
  // Field 21:20 is forced to zero on load
  always_ff @(posedge clk) begin
    load_val_ff <= {accum_in[23:22], 2'h0, accum_in[19:0]};
  end
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req_start;
    $rose(req) && !ack;
  endsequence
  sequence s_long_wait;
    wait_cnt_ff == 16'h01C2;
  endsequence
  a_lamp_sticky: assert property (
    error_indicator_lamp |=> error_indicator_lamp)
    else $error("lamp went dark");
  a_lamp_on_soft: assert property (
    ext_prio_irq |-> error_indicator_lamp)
    else $error("soft error without lamp");
  a_irq_exclusive: assert property (
    !(exec_trap_irq && ext_prio_irq))
    else $error("both interrupts at once");
  a_zero_field: assert property (
    error_address_capture[21:20] == 2'h0)
    else $error("capture bits 21:20 not zero");
  a_load_value: assert property (
    load_error_address_instr |=> error_address_capture == load_val_ff)
    else $error("capture load wrong");
  a_cap_change: assert property (
    !$stable(error_address_capture) |-> $past(load_error_address_instr)
    || $past(exec_trap_irq) || $past(ext_prio_irq)
    || exec_trap_irq || ext_prio_irq)
    else $error("capture changed without cause");
  a_req_answered: assert property (
    s_req_start |-> ##[1:520] ack)
    else $error("request never answered");
  a_timeout_trap: assert property (
    s_long_wait |-> ##[1:80] exec_trap_irq)
    else $error("no trap on time-out");
  a_no_early_trap: assert property (
    (wait_cnt_ff > 16'h000A && wait_cnt_ff < 16'h01E0) |-> !exec_trap_irq)
    else $error("time-out trap too early");
  a_soft_then_ack: assert property (
    ext_prio_irq |-> ##[1:3] ack)
    else $error("soft error not followed by ack");
endmodule : mecr_checker
`default_nettype wire

//--- testbench/mecr_req_model.sv
// Requester model: a CPU or I/O channel making one access at a time
`default_nettype none
module mecr_req_model (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [23:0] rdata,
  // Request lines
  output var  logic        req,
  output var  logic        req_we,
  output var  logic [19:0] req_addr,
  output var  logic [23:0] req_wdata,
  output var  logic [1:0]  req_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    req       = 1'b0;
    req_we    = 1'b0;
    req_addr  = 20'h00000;
    req_wdata = 24'h000000;
    req_cause = 2'h0;
  end
  // One access: raise after an edge, hold until ack, then let go
  task automatic access(input logic we, input logic [19:0] addr,
                        input logic [23:0] wdata, input logic [1:0] cause,
                        output logic [23:0] data, output int cycles);
    @(posedge clk);
    #1;
    req       = 1'b1;
    req_we    = we;
    req_addr  = addr;
    req_wdata = wdata;  // Data bits only, check bits are not ours
    req_cause = cause;
    cycles    = 0;
    do begin
      @(posedge clk);
      #1;
      cycles++;
    end while (ack !== 1'b1 && cycles < 1000);
    data      = rdata;
    req       = 1'b0;
    // Released address, data and cause lines flip so a stale value is never mistaken for live
    req_addr  = ~addr;
    req_wdata = ~wdata;
    req_cause = ~cause;
    repeat (2) @(posedge clk);
    #1;
  endtask : access
endmodule : mecr_req_model
`default_nettype wire

//--- testbench/mecr_top_tb.sv
// Testbench: scenarios for the memory error correct/report block
`default_nettype none
module mecr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic        clk, resetn, parity_only, mem_respond;
  logic        read_error_address_instr, load_error_address_instr;
  logic [28:0] inject_flip;   // Stored-bit flips for fault tests
  logic [23:0] accum_in, rdata, req_wdata, error_address_capture, got;
  logic        req, req_we, ack, error_indicator_lamp;
  logic        exec_trap_irq, ext_prio_irq;
  logic [19:0] req_addr;
  logic [1:0]  req_cause;
  int          n_errors = 0, samples_checked = 0, cyc, n_cycles = 0;
  int          n_hard = 0, n_soft = 0;  // Interrupt pulses seen
  mecr_top i_dut (.clk(clk), .resetn(resetn), .req(req), .req_we(req_we),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_cause(req_cause),
    .parity_only(parity_only), .mem_respond(mem_respond),
    .inject_flip(inject_flip), .ack(ack), .rdata(rdata),
    .error_indicator_lamp(error_indicator_lamp),
    .exec_trap_irq(exec_trap_irq), .ext_prio_irq(ext_prio_irq),
    .read_error_address_instr(read_error_address_instr),
    .load_error_address_instr(load_error_address_instr),
    .accum_in(accum_in), .error_address_capture(error_address_capture));
  mecr_req_model i_req (.clk(clk), .ack(ack), .rdata(rdata), .req(req),
    .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_cause(req_cause));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulses counted mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (exec_trap_irq === 1'b1) n_hard++;
    if (ext_prio_irq === 1'b1) n_soft++;
  end
  // Hang guard, far beyond the several hundred cycles the run needs
  always @(posedge clk) begin
    n_cycles++;
    if (n_cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One-cycle pulse on the capture read or load instruction
  task automatic pulse_instr(input logic is_load);
    if (is_load) load_error_address_instr = 1'b1;
    else read_error_address_instr = 1'b1;
    @(posedge clk);
    #1;
    load_error_address_instr = 1'b0;
    read_error_address_instr = 1'b0;
  endtask : pulse_instr
  // Write with a flip mask, then read the word back
  task automatic wr_rd(input logic [19:0] a, input logic [23:0] d,
                       input logic [28:0] flip, input logic [1:0] c);
    inject_flip = flip;
    i_req.access(1'b1, a, d, c, got, cyc);
    inject_flip = 29'h00000000;
    i_req.access(1'b0, a, 24'h000000, c, got, cyc);
  endtask : wr_rd
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_clean;
    check("capture at reset", 24'h000000, error_address_capture);
    wr_rd(20'h00011, 24'hA5C3F0, 29'h00000000, mecr_pkg::CAUSE_OPERAND);
    check("clean data", 24'hA5C3F0, got);
    check("lamp clean", 24'h0, {23'h0, error_indicator_lamp});
  endtask : t_clean
  // Single flipped bit: corrected, soft, written back
  task automatic t_soft;
    wr_rd(20'h00022, 24'h3C5A96, 29'h00000020, mecr_pkg::CAUSE_OPERAND);
    check("soft data", 24'h3C5A96, got);
    check("soft count", 24'h1, 24'(n_soft));
    check("hard count", 24'h0, 24'(n_hard));
    check("lamp", 24'h1, {23'h0, error_indicator_lamp});
    check("cap soft", 24'h400022, error_address_capture);
    i_req.access(1'b0, 20'h00022, 24'h0, 2'h1, got, cyc);
    check("reread data", 24'h3C5A96, got);
    i_req.access(1'b0, 20'h00011, 24'h0, 2'h1, got, cyc);
    i_req.access(1'b0, 20'h00022, 24'h0, 2'h1, got, cyc);
    check("written back", 24'h3C5A96, got);
    check("no new soft", 24'h1, 24'(n_soft));
  endtask : t_soft
  // Uncorrectable flips: hard, replaces soft, second hard is ignored
  task automatic t_hard;
    wr_rd(20'h00033, 24'h123456, 29'h00800001, mecr_pkg::CAUSE_IO);
    check("hard count", 24'h1, 24'(n_hard));
    check("cap hard", 24'h800033, error_address_capture);
    wr_rd(20'h00034, 24'h654321, 29'h00800001, mecr_pkg::CAUSE_IFETCH);
    check("hard count 2", 24'h2, 24'(n_hard));
    check("cap kept", 24'h800033, error_address_capture);
  endtask : t_hard
  // Re-armed capture, parity-only module gives hard on one flip
  task automatic t_rearm;
    pulse_instr(1'b0);
    parity_only = 1'b1;
    wr_rd(20'h00035, 24'h0F0F0F, 29'h00000100, mecr_pkg::CAUSE_IFETCH);
    parity_only = 1'b0;
    check("parity hard", 24'h3, 24'(n_hard));
    check("parity soft", 24'h1, 24'(n_soft));
    check("cap rearmed", 24'h000035, error_address_capture);
  endtask : t_rearm
  // Silent storage: time-out after 500 cycles
  task automatic t_timeout;
    pulse_instr(1'b0);
    mem_respond = 1'b0;
    i_req.access(1'b0, 20'h00040, 24'h0, 2'h1, got, cyc);
    mem_respond = 1'b1;
    check("tmo wait", 24'h1, {23'h0, cyc >= 500 && cyc <= 504});
    check("tmo trap", 24'h4, 24'(n_hard));
    check("cap tmo", 24'hC00040, error_address_capture);
  endtask : t_timeout
  // Diagnostic load with 21:20 forced low
  task automatic t_load;
    accum_in = 24'hFFFFFF;
    pulse_instr(1'b1);
    check("cap load", 24'hCFFFFF, error_address_capture);
  endtask : t_load
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    parity_only = 1'b0;
    mem_respond = 1'b1;
    inject_flip = 29'h00000000;
    read_error_address_instr = 1'b0;
    load_error_address_instr = 1'b0;
    accum_in = 24'h000000;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_clean();
    t_soft();
    t_hard();
    t_rearm();
    t_timeout();
    t_load();
    print_verdict();
  end
endmodule : mecr_top_tb
bind mecr_top mecr_checker i_chk (.clk(clk), .resetn(resetn), .req(req),
  .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata),
  .req_cause(req_cause), .parity_only(parity_only),
  .mem_respond(mem_respond), .inject_flip(inject_flip), .ack(ack),
  .rdata(rdata), .error_indicator_lamp(error_indicator_lamp),
  .exec_trap_irq(exec_trap_irq), .ext_prio_irq(ext_prio_irq),
  .read_error_address_instr(read_error_address_instr),
  .load_error_address_instr(load_error_address_instr),
  .accum_in(accum_in), .error_address_capture(error_address_capture));
`default_nettype wire
